// File: include/edm_params.svh
/*
 * constants for the edo/sdram memory port: field widths, strobe patterns
 * and timing counts.
 * assumes inclusion by bare name from any design or package file.
 */
`ifndef EDM_PARAMS_SVH
`define EDM_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define EDM_DATA_W 64
`define EDM_ECC_W 8
`define EDM_ROWS 6
`define EDM_LANES 8
`define EDM_ADDR_W 14

// ----------------------------------------------------------------
// constant values
// ----------------------------------------------------------------
`define EDM_ROWS_OFF 6'h3F
`define EDM_LANES_OFF 8'hFF
`define EDM_LANES_ON 8'h00
`define EDM_ADDR_ZERO 14'h0000
`define EDM_DATA_ZERO 64'h0000000000000000
`define EDM_ECC_ZERO 8'h00
`define EDM_CNT_ZERO 3'h0
`define EDM_CNT_ONE 3'h1

// ----------------------------------------------------------------
// timing in memory clocks
// ----------------------------------------------------------------
`define EDM_T_RCD 3'h2
`define EDM_T_CAS 3'h2
`define EDM_T_RP 3'h2

`endif

// File: include/edm_pkg.sv
/*
 * types shared by the memory port modules.
 * assumes edm_params.svh is on the include path.
 */
`include "edm_params.svh"

package edm_pkg;
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		EDM_IDLE = 3'b000,
		EDM_ROW = 3'b001,
		EDM_COL = 3'b010,
		EDM_DATA = 3'b011,
		EDM_PRE = 3'b100
	} edm_state_t;

	// memory type selection
	typedef enum logic {
		EDM_EDO = 1'b0,
		EDM_SDR = 1'b1
	} edm_mode_t;
endpackage

// File: include/edm_pin_if.sv
/*
 * interface carrying pin-level strobe decisions from the sequencer to
 * the pin mapper.
 * assumes one mclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "edm_params.svh"

interface edm_pin_if;
	logic row_act; // row phase active
	logic col_act; // column phase active
	logic wr; // access is a write
	logic pre; // sdram precharge cycle
	logic [`EDM_ROWS-1:0] row_sel; // one-hot row
	logic [`EDM_LANES-1:0] byte_en; // byte lanes to write
	modport seq (output row_act, col_act, wr, pre, row_sel, byte_en);
	modport map (input row_act, col_act, wr, pre, row_sel, byte_en);
endinterface

`default_nettype wire

// File: core/edm_strobe_map.sv
/*
 * maps abstract strobe decisions onto the shared strobe pins for
 * the selected memory type; purely combinational.
 * assumes the caller registers the results.
 */
`timescale 1ns/1ps
`default_nettype none
`include "edm_params.svh"

module edm_strobe_map
	import edm_pkg::*;
(
	edm_pin_if.map pin,
	input wire edm_mode_t mode,
	output logic [`EDM_ROWS-1:0] row_n,
	output logic [`EDM_LANES-1:0] col_n,
	output logic we_n,
	output logic sras_n,
	output logic scas_n
);
	// ----------------------------------------------------------------
	// strobe mapping
	// ----------------------------------------------------------------
	// shared pins change meaning with the memory type
	always_comb begin
		row_n = `EDM_ROWS_OFF;
		col_n = `EDM_LANES_OFF;
		we_n = 1'b1;
		sras_n = 1'b1;
		scas_n = 1'b1;
		if (mode == EDM_EDO) begin // R12
			// row strobes held from the row phase through the data phase
			if (pin.row_act)
				row_n = ~pin.row_sel; // R2
			// column strobes pick written bytes, all on reads
			if (pin.col_act)
				col_n = pin.wr ? ~pin.byte_en : `EDM_LANES_ON; // R4
			we_n = ~(pin.wr && pin.col_act); // R7
		end else begin
			// chip select only on command cycles
			if (pin.row_act || pin.col_act || pin.pre)
				row_n = ~pin.row_sel; // R3
			sras_n = ~(pin.row_act || pin.pre); // R8
			scas_n = ~pin.col_act; // R9
			we_n = ~((pin.wr && pin.col_act) || pin.pre); // R7
			// mask high blocks a byte; reads keep all enabled
			col_n = pin.wr ? ~pin.byte_en : `EDM_LANES_ON; // R5
		end
	end
endmodule

`default_nettype wire

// File: core/edm_memory_port.sv
/*
 * memory-side port of a dram controller: one access at a time to edo
 * or sdram over shared strobes, 64-bit data plus 8-bit check lane.
 * assumes a request stays stable while req is high until done pulses,
 * and the memory type is static after reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "edm_params.svh"

// Notes on behaviour
// R1 - eight check bits driven on write, sampled read
// R2 - edo: row strobes pick the dram row
// R3 - sdram: chip selects gate every command
// R4 - edo: column strobes pick the column
// R5 - sdram: column pins become byte masks
// R6 - one fourteen-bit multiplexed address set only
// R7 - one write enable for both modes
// R8 - sdram row strobe latches row, precharges
// R9 - sdram column strobe latches column address
// R10 - six independent clock enables, low powers down
// R11 - 64-bit bidirectional data bus to dram
// R12 - static mode picks edo or sdram meaning
module edm_memory_port
	import edm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic sdram_mode,
	input wire logic req,
	input wire logic req_wr,
	input wire logic [2:0] req_row,
	input wire logic [`EDM_ADDR_W-1:0] req_row_addr,
	input wire logic [`EDM_ADDR_W-1:0] req_col_addr,
	input wire logic [`EDM_LANES-1:0] req_byte_en,
	input wire logic [`EDM_DATA_W-1:0] req_wdata,
	input wire logic [`EDM_ECC_W-1:0] req_wecc,
	input wire logic [`EDM_ROWS-1:0] row_powered,
	output logic done,
	output logic [`EDM_DATA_W-1:0] rd_data,
	output logic [`EDM_ECC_W-1:0] rd_ecc,
	output logic [`EDM_ROWS-1:0] row_strobe_n,
	output logic [`EDM_LANES-1:0] column_strobe_n,
	output logic [`EDM_ADDR_W-1:0] mem_addr_set_b,
	output logic write_enable_n,
	output logic sd_row_strobe_n,
	output logic sd_col_strobe_n,
	output logic [`EDM_ROWS-1:0] clock_enable,
	input wire logic [`EDM_DATA_W-1:0] mem_data_bus_i,
	output logic [`EDM_DATA_W-1:0] mem_data_bus_o,
	output logic mem_data_bus_oe,
	input wire logic [`EDM_ECC_W-1:0] ecc_check_lane_i,
	output logic [`EDM_ECC_W-1:0] ecc_check_lane_o,
	output logic ecc_check_lane_oe
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	edm_pin_if pin(); // sequencer to mapper
	edm_state_t st_ff, nxt_st; // sequencer state
	edm_mode_t mode_ff, nxt_mode; // latched memory type
	logic [2:0] cnt_ff, nxt_cnt; // phase wait counter
	logic done_ff, nxt_done; // completion pulse
	logic [`EDM_DATA_W-1:0] rdat_ff, nxt_rdat; // captured read data
	logic [`EDM_ECC_W-1:0] recc_ff, nxt_recc; // captured check bits
	logic [`EDM_ADDR_W-1:0] addr_ff, nxt_addr; // address pins
	logic [`EDM_ROWS-1:0] cke_ff, nxt_cke; // clock enables
	logic doe_ff, nxt_doe; // data bus drive
	logic [`EDM_DATA_W-1:0] dout_ff, nxt_dout; // write data
	logic [`EDM_ECC_W-1:0] eout_ff, nxt_eout; // write check bits
	logic [`EDM_ROWS-1:0] rown_ff; // registered pin copies
	logic [`EDM_LANES-1:0] coln_ff;
	logic wen_ff, srasn_ff, scasn_ff;
	logic [`EDM_ROWS-1:0] m_row_n; // mapper results
	logic [`EDM_LANES-1:0] m_col_n;
	logic m_we_n, m_sras_n, m_scas_n;

	// one-hot decode of a row number; rows above five select none
	function automatic logic [`EDM_ROWS-1:0] row_onehot(
		input logic [2:0] r);
		logic [`EDM_ROWS-1:0] v;
		v = '0;
		for (int i = 0; i < `EDM_ROWS; i++) begin
			if (r == 3'(i))
				v[i] = 1'b1;
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// sequencer next state
	// ----------------------------------------------------------------
	// row phase, column phase, data phase, then close the row
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		nxt_rdat = rdat_ff;
		nxt_recc = recc_ff;
		nxt_addr = addr_ff;
		nxt_doe = doe_ff;
		nxt_dout = dout_ff;
		nxt_eout = eout_ff;
		// mode is sampled only while idle so it never changes mid-access
		nxt_mode = (st_ff == EDM_IDLE) ?
			(sdram_mode ? EDM_SDR : EDM_EDO) : mode_ff; // R12
		nxt_cke = row_powered; // R10
		case (st_ff)
			EDM_IDLE: begin
				nxt_doe = 1'b0;
				if (req && !done_ff) begin
					nxt_st = EDM_ROW;
					nxt_cnt = `EDM_T_RCD;
					nxt_addr = req_row_addr; // R6
				end
			end
			EDM_ROW: begin
				// row address stands for the row-to-column delay
				if (cnt_ff == `EDM_CNT_ONE) begin
					nxt_st = EDM_COL;
					nxt_addr = req_col_addr; // R6
					nxt_doe = req_wr; // R11
					nxt_dout = req_wdata; // R11
					nxt_eout = req_wecc; // R1
				end else
					nxt_cnt = cnt_ff - `EDM_CNT_ONE;
			end
			EDM_COL: begin
				nxt_st = EDM_DATA;
				nxt_cnt = `EDM_T_CAS;
			end
			EDM_DATA: begin
				// read data lands after the cas latency
				if (cnt_ff == `EDM_CNT_ONE) begin
					if (!req_wr) begin
						nxt_rdat = mem_data_bus_i; // R11
						nxt_recc = ecc_check_lane_i; // R1
					end
					nxt_doe = 1'b0;
					nxt_st = EDM_PRE;
					nxt_cnt = `EDM_T_RP;
				end else
					nxt_cnt = cnt_ff - `EDM_CNT_ONE;
			end
			EDM_PRE: begin
				if (cnt_ff == `EDM_CNT_ONE) begin
					nxt_st = EDM_IDLE;
					nxt_done = 1'b1;
					nxt_cnt = `EDM_CNT_ZERO;
				end else
					nxt_cnt = cnt_ff - `EDM_CNT_ONE;
			end
			default: begin
				nxt_st = EDM_IDLE;
				nxt_cnt = `EDM_CNT_ZERO;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// strobe decisions for the mapper
	// ----------------------------------------------------------------
	assign pin.row_act = (st_ff == EDM_ROW) ? 1'b1 :
		(mode_ff == EDM_EDO) && (st_ff == EDM_COL || st_ff == EDM_DATA);
	// edo holds cas through data; sdram issues it for one cycle
	assign pin.col_act = (st_ff == EDM_COL) ||
		((mode_ff == EDM_EDO) && (st_ff == EDM_DATA));
	assign pin.pre = (mode_ff == EDM_SDR) && (st_ff == EDM_PRE) &&
		(cnt_ff == `EDM_T_RP);
	assign pin.wr = req_wr;
	assign pin.row_sel = row_onehot(req_row);
	assign pin.byte_en = req_byte_en;

	edm_strobe_map u_map (
		.pin(pin.map),
		.mode(mode_ff),
		.row_n(m_row_n),
		.col_n(m_col_n),
		.we_n(m_we_n),
		.sras_n(m_sras_n),
		.scas_n(m_scas_n)
	);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// pins are registered so outputs are glitch free
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= EDM_IDLE;
			mode_ff <= EDM_EDO;
			cnt_ff <= `EDM_CNT_ZERO;
			done_ff <= 1'b0;
			rdat_ff <= `EDM_DATA_ZERO;
			recc_ff <= `EDM_ECC_ZERO;
			addr_ff <= `EDM_ADDR_ZERO;
			cke_ff <= `EDM_ROWS_OFF;
			doe_ff <= 1'b0;
			dout_ff <= `EDM_DATA_ZERO;
			eout_ff <= `EDM_ECC_ZERO;
			rown_ff <= `EDM_ROWS_OFF;
			coln_ff <= `EDM_LANES_OFF;
			wen_ff <= 1'b1;
			srasn_ff <= 1'b1;
			scasn_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			mode_ff <= nxt_mode;
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
			rdat_ff <= nxt_rdat;
			recc_ff <= nxt_recc;
			addr_ff <= nxt_addr;
			cke_ff <= nxt_cke; // R10
			doe_ff <= nxt_doe;
			dout_ff <= nxt_dout;
			eout_ff <= nxt_eout;
			rown_ff <= m_row_n; // R2 R3
			coln_ff <= m_col_n; // R4 R5
			wen_ff <= m_we_n; // R7
			srasn_ff <= m_sras_n; // R8
			scasn_ff <= m_scas_n; // R9
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign done = done_ff;
	assign rd_data = rdat_ff;
	assign rd_ecc = recc_ff;
	assign row_strobe_n = rown_ff;
	assign column_strobe_n = coln_ff;
	assign mem_addr_set_b = addr_ff;
	assign write_enable_n = wen_ff;
	assign sd_row_strobe_n = srasn_ff;
	assign sd_col_strobe_n = scasn_ff;
	assign clock_enable = cke_ff;
	assign mem_data_bus_o = dout_ff;
	assign mem_data_bus_oe = doe_ff; // R11
	assign ecc_check_lane_o = eout_ff;
	assign ecc_check_lane_oe = doe_ff; // R1
endmodule

`default_nettype wire

// File: sim/edm_memory_port_props.sv
/* pin-level checks for the memory port.
   assumes one mclk domain, bound to edm_memory_port. */
`timescale 1ns/1ps
`default_nettype none
module edm_mp_props (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sdram_mode,
	input wire logic req,
	input wire logic [13:0] req_row_addr,
	input wire logic [13:0] req_col_addr,
	input wire logic [5:0] row_powered,
	input wire logic done,
	input wire logic [5:0] row_strobe_n,
	input wire logic [13:0] mem_addr_set_b,
	input wire logic write_enable_n,
	input wire logic sd_row_strobe_n,
	input wire logic sd_col_strobe_n,
	input wire logic [5:0] clock_enable,
	input wire logic mem_data_bus_oe,
	input wire logic ecc_check_lane_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// new request seen while the port is idle
	sequence s_new_req;
		$rose(req) && !done;
	endsequence
	property p_done_bound;
		s_new_req |-> ##[1:9] done;
	endproperty
	a_done_bound: assert property (p_done_bound) else $error("no done");
	property p_done_pulse;
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("long done");
	// vacuous on the first edge out of reset
	property p_cke;
		!$past(rst) |-> clock_enable == $past(row_powered);
	endproperty
	a_cke: assert property (p_cke) else $error("cke lag");
	property p_edo_quiet;
		!sdram_mode [*3] |-> sd_row_strobe_n && sd_col_strobe_n;
	endproperty
	a_edo_quiet: assert property (p_edo_quiet) else $error("sd strobe");
	property p_one_row;
		$onehot0(~row_strobe_n);
	endproperty
	a_one_row: assert property (p_one_row) else $error("two rows");
	property p_lane_oe;
		mem_data_bus_oe == ecc_check_lane_oe;
	endproperty
	a_lane_oe: assert property (p_lane_oe) else $error("ecc oe");
	// precharge also drops write enable, so it is left out
	property p_row_addr;
		$fell(sd_row_strobe_n) && write_enable_n |->
			mem_addr_set_b == req_row_addr;
	endproperty
	a_row_addr: assert property (p_row_addr) else $error("row addr");
	property p_col_addr;
		$fell(sd_col_strobe_n) |-> mem_addr_set_b == req_col_addr;
	endproperty
	a_col_addr: assert property (p_col_addr) else $error("col addr");
endmodule
bind edm_memory_port edm_mp_props u_props (.mclk, .rst, .sdram_mode,
	.req, .req_row_addr, .req_col_addr, .row_powered, .done,
	.row_strobe_n, .mem_addr_set_b, .write_enable_n, .sd_row_strobe_n,
	.sd_col_strobe_n, .clock_enable, .mem_data_bus_oe, .ecc_check_lane_oe);
`default_nettype wire

// File: sim/edm_mem_model.sv
/* behavioural dram bank, keyed by column address.
   assumes strobes come from edm_memory_port. */
`timescale 1ns/1ps
`default_nettype none
module edm_mem_model (
	input wire logic mclk,
	input wire logic sdram_mode,
	input wire logic [5:0] row_strobe_n,
	input wire logic [7:0] column_strobe_n,
	input wire logic [13:0] mem_addr_set_b,
	input wire logic write_enable_n,
	input wire logic sd_col_strobe_n,
	input wire logic [5:0] clock_enable,
	input wire logic [71:0] wr_bus,
	output logic [71:0] rd_bus
);
	logic [71:0] mem [logic [13:0]]; // stored words
	logic [71:0] last = '0; // last word put out
	int hold = 0; // cycles the read word stays valid
	// commands count only with a row selected and, on sdram, powered
	wire sel = sdram_mode ? |(~row_strobe_n & clock_enable)
		: row_strobe_n != 6'h3F;
	wire cmd = sel && (sdram_mode ? !sd_col_strobe_n
		: column_strobe_n != 8'hFF);
	always @(posedge mclk) begin
		if (cmd && !write_enable_n) begin
			if (!mem.exists(mem_addr_set_b))
				mem[mem_addr_set_b] = '0;
			for (int b = 0; b < 8; b++)
				if (!column_strobe_n[b])
					mem[mem_addr_set_b][b*8+:8] = wr_bus[b*8+:8];
			mem[mem_addr_set_b][71:64] = wr_bus[71:64];
		end else if (cmd) begin
			last = mem.exists(mem_addr_set_b) ? mem[mem_addr_set_b] : '0;
			hold = 3;
		end else if (hold > 0)
			hold--;
	end
	// released bus shows the inverse so stale data never matches
	assign rd_bus = hold > 0 ? last : ~last;
endmodule
`default_nettype wire

// File: sim/testbench.sv
/* self-checking bench for edm_memory_port.
   assumes the dram model on the far side. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk, rst, sdram_mode, req, req_wr, done;
	logic write_enable_n, sd_row_strobe_n, sd_col_strobe_n;
	logic mem_data_bus_oe, ecc_check_lane_oe;
	logic [2:0] req_row;
	logic [13:0] req_row_addr, req_col_addr, mem_addr_set_b;
	logic [7:0] req_byte_en, req_wecc, rd_ecc, column_strobe_n;
	logic [7:0] ecc_check_lane_i, ecc_check_lane_o;
	logic [63:0] req_wdata, rd_data, mem_data_bus_i, mem_data_bus_o;
	logic [5:0] row_powered, row_strobe_n, clock_enable;
	int fail_count = 0;
	int n_tests = 0;
	edm_memory_port u_dut (.mclk(mclk), .rst(rst), .sdram_mode(sdram_mode),
		.req(req), .req_wr(req_wr), .req_row(req_row),
		.req_row_addr(req_row_addr), .req_col_addr(req_col_addr),
		.req_byte_en(req_byte_en), .req_wdata(req_wdata),
		.req_wecc(req_wecc), .row_powered(row_powered), .done(done),
		.rd_data(rd_data), .rd_ecc(rd_ecc), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n),
		.mem_addr_set_b(mem_addr_set_b), .write_enable_n(write_enable_n),
		.sd_row_strobe_n(sd_row_strobe_n),
		.sd_col_strobe_n(sd_col_strobe_n), .clock_enable(clock_enable),
		.mem_data_bus_i(mem_data_bus_i), .mem_data_bus_o(mem_data_bus_o),
		.mem_data_bus_oe(mem_data_bus_oe),
		.ecc_check_lane_i(ecc_check_lane_i),
		.ecc_check_lane_o(ecc_check_lane_o),
		.ecc_check_lane_oe(ecc_check_lane_oe));
	edm_mem_model u_mem (.mclk, .sdram_mode, .row_strobe_n,
		.column_strobe_n, .mem_addr_set_b, .write_enable_n,
		.sd_col_strobe_n, .clock_enable,
		.wr_bus({ecc_check_lane_o, mem_data_bus_o}),
		.rd_bus({ecc_check_lane_i, mem_data_bus_i}));
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(string nm, logic [71:0] exp, logic [71:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one access; req held until done, then dropped a half cycle later
	task automatic access(logic wr, logic [2:0] row, logic [13:0] ca,
		logic [7:0] be, logic [71:0] wd);
		int n;
		logic saw_oe;
		saw_oe = 1'b0;
		@(negedge mclk);
		req_wr = wr;
		req_row = row;
		req_col_addr = ca;
		req_row_addr = ca ^ 14'h2AAA;
		req_byte_en = be;
		{req_wecc, req_wdata} = wd;
		req = 1'b1;
		n = 0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
			saw_oe = saw_oe | (mem_data_bus_oe === 1'b1);
		end
		check("done", 1'b1, done);
		// 2 row + 1 col + 2 data + 2 precharge + the taking edge
		check("latency", 72'd8, n);
		check("bus drive", wr, saw_oe);
		@(negedge mclk);
		req = 1'b0;
	endtask
	task automatic set_mode(logic m);
		sdram_mode = m;
		repeat (3) @(negedge mclk);
	endtask
	task automatic t_edo;
		set_mode(1'b0);
		access(1, 0, 14'h0005, 8'hFF, 72'hA5_0123456789ABCDEF);
		access(1, 5, 14'h0006, 8'hFF, 72'h3C_FEDCBA9876543210);
		access(0, 0, 14'h0005, 8'h00, '0);
		check("edo rd", 72'hA5_0123456789ABCDEF, {rd_ecc, rd_data});
		access(0, 5, 14'h0006, 8'h00, '0);
		check("edo rd2", 72'h3C_FEDCBA9876543210, {rd_ecc, rd_data});
	endtask
	task automatic t_sdr;
		set_mode(1'b1);
		access(1, 5, 14'h3FF9, 8'hFF, 72'h11_1111111122222222);
		access(1, 5, 14'h3FF9, 8'h0F, 72'h11_AAAAAAAABBBBBBBB);
		access(0, 5, 14'h3FF9, 8'h00, '0);
		check("sd merge", 64'h11111111BBBBBBBB, rd_data);
		set_mode(1'b0);
		access(0, 5, 14'h3FF9, 8'h00, '0);
		check("mode back", 64'h11111111BBBBBBBB, rd_data);
	endtask
	task automatic t_cke;
		row_powered = 6'h2A;
		repeat (2) @(negedge mclk);
		check("cke 2A", 6'h2A, clock_enable);
		row_powered = 6'h15;
		repeat (2) @(negedge mclk);
		check("cke 15", 6'h15, clock_enable);
		row_powered = 6'h3F;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		finish_test;
	end
	initial begin
		{rst, req, req_wr, sdram_mode, req_row} = 7'h40;
		{req_row_addr, req_col_addr, req_byte_en} = '0;
		{req_wdata, req_wecc} = '0;
		row_powered = 6'h3F;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		t_cke;
		t_edo;
		t_sdr;
		finish_test;
	end
endmodule
`default_nettype wire
